//--- hw/iskx_regs.vh
// constants for the increment-and-skip execute block
`ifndef ISKX_REGS_VH
`define ISKX_REGS_VH
// opcode upper six bits
`define ISKX_OP_ZSKIP 6'h0F
`define ISKX_OP_NZSKIP 6'h12
// field positions inside the 16-bit instruction word
`define ISKX_OP_MSB 15
`define ISKX_OP_LSB 10
`define ISKX_D_BIT 9
`define ISKX_A_BIT 8
`define ISKX_F_MSB 7
// highest file address that uses indexed literal offset
`define ISKX_IDX_LIMIT 8'h5F
// access bank split: low part maps to bank 0, rest to bank 15
`define ISKX_ACC_HIBANK 4'hF
// reset values
`define ISKX_RST_BYTE 8'h00
`define ISKX_RST_ADDR 12'h000
`endif

//--- hw/iskx_addr_res.v
// operand address resolution for the increment-and-skip block
`timescale 1ns/1ns
module iskx_addr_res
(
   input wire a_bit_in,
   input wire [7:0] f_addr_in,
   input wire [3:0] bank_pointer_in,
   input wire ext_set_en_in,
   input wire [7:0] index_base_in,
   output reg [11:0] addr_out,
   output reg indexed_out
);
`include "iskx_regs.vh"
   // ==========================================
   // address mux
   always @*
   begin
      indexed_out = 1'b0;
      if (a_bit_in)
         addr_out = {bank_pointer_in, f_addr_in};
      else if (ext_set_en_in && f_addr_in <= `ISKX_IDX_LIMIT)
      begin
         // only the low page of the index pointer is modelled
         addr_out = {4'h0, index_base_in + f_addr_in};
         indexed_out = 1'b1;
      end
      else if (f_addr_in[7])
         addr_out = {`ISKX_ACC_HIBANK, f_addr_in};
      else
         addr_out = {4'h0, f_addr_in};
   end
endmodule

//--- hw/iskx_exec.v
// decode and execute for increment-and-skip-on-zero and -on-nonzero
// Function
// - pattern 0011 11 d a f decodes as zero-skip; increments f by one
// - d zero writes accumulator; d one writes file register back
// - zero-skip with zero result discards fetched next instruction as a nop
// - pattern 0100 10 d a f is nonzero-skip; skips when result nonzero
// - a clear uses access bank; a set uses bank_pointer for general_file_bank
// - extended set, a clear, f at most 5Fh uses indexed literal offset
`timescale 1ns/1ns
module iskx_exec
(
   input wire core_clk_in,
   input wire srst_in,
   input wire instr_valid_in,
   input wire [15:0] instr_in,
   input wire [3:0] bank_pointer_in,
   input wire ext_set_en_in,
   input wire [7:0] index_base_in,
   input wire [7:0] file_rdata_in,
   output reg [11:0] file_addr_out,
   output reg file_rd_out,
   output reg file_we_out,
   output reg [11:0] file_waddr_out,
   output reg [7:0] file_wdata_out,
   output reg acc_we_out,
   output reg [7:0] acc_wdata_out,
   output reg skip_out,
   output reg indexed_out,
   output reg busy_out
);
`include "iskx_regs.vh"
   // ==========================================
   // states
   localparam ST_IDLE = 2'h0;
   localparam ST_EXEC = 2'h1;
   localparam ST_KILL = 2'h2;
   reg [1:0] state;
   reg [1:0] next_state;
   reg is_nz;
   reg dest_file;
   wire [11:0] res_addr;
   wire res_idx;
   wire [7:0] sum;
   wire hit_z;
   wire hit_nz;
   // ==========================================
   // decode
   function is_op;
      input [15:0] w;
      input [5:0] op;
      begin
         is_op = (w[`ISKX_OP_MSB:`ISKX_OP_LSB] == op);
      end
   endfunction
   assign hit_z = instr_valid_in && is_op(instr_in, `ISKX_OP_ZSKIP);
   assign hit_nz = instr_valid_in && is_op(instr_in, `ISKX_OP_NZSKIP);
   assign sum = file_rdata_in + 8'h01;
   iskx_addr_res u_addr
   (
      .a_bit_in(instr_in[`ISKX_A_BIT]),
      .f_addr_in(instr_in[`ISKX_F_MSB:0]),
      .bank_pointer_in(bank_pointer_in),
      .ext_set_en_in(ext_set_en_in),
      .index_base_in(index_base_in),
      .addr_out(res_addr),
      .indexed_out(res_idx)
   );
   // ==========================================
   // sequencing
   always @*
   begin
      case (state)
         ST_IDLE: next_state = (hit_z || hit_nz) ? ST_EXEC : ST_IDLE;
         ST_EXEC:
         begin
            // skip decision
            if ((sum == `ISKX_RST_BYTE) != is_nz)
               next_state = ST_KILL;
            else
               next_state = ST_IDLE;
         end
         ST_KILL: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end
   always @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         state <= ST_IDLE;
         is_nz <= 1'b0;
         dest_file <= 1'b0;
         file_addr_out <= `ISKX_RST_ADDR;
         file_rd_out <= 1'b0;
         file_we_out <= 1'b0;
         file_waddr_out <= `ISKX_RST_ADDR;
         file_wdata_out <= `ISKX_RST_BYTE;
         acc_we_out <= 1'b0;
         acc_wdata_out <= `ISKX_RST_BYTE;
         skip_out <= 1'b0;
         indexed_out <= 1'b0;
         busy_out <= 1'b0;
      end
      else
      begin
         state <= next_state;
         file_rd_out <= 1'b0;
         file_we_out <= 1'b0;
         acc_we_out <= 1'b0;
         skip_out <= 1'b0;
         busy_out <= (next_state != ST_IDLE);
         if (state == ST_IDLE && (hit_z || hit_nz))
         begin
            // latch operand address; read data returns next cycle
            is_nz <= hit_nz;
            dest_file <= instr_in[`ISKX_D_BIT];
            file_addr_out <= res_addr;
            indexed_out <= res_idx;
            file_rd_out <= 1'b1;
         end
         if (state == ST_EXEC)
         begin
            if (dest_file)
            begin
               file_we_out <= 1'b1;
               file_waddr_out <= file_addr_out;
               file_wdata_out <= sum;
            end
            else
            begin
               acc_we_out <= 1'b1;
               acc_wdata_out <= sum;
            end
            // pulse tells fetch stage to replace the prefetched word by a nop
            skip_out <= (next_state == ST_KILL);
         end
      end
   end
endmodule

//--- bench/iskx_props.sv
// assertion checker for the increment-and-skip block
`timescale 1ns/1ns
module iskx_props
(
   input wire core_clk_in,
   input wire srst_in,
   input wire instr_valid_in,
   input wire [15:0] instr_in,
   input wire [3:0] bank_pointer_in,
   input wire ext_set_en_in,
   input wire [7:0] index_base_in,
   input wire [7:0] file_rdata_in,
   input wire [11:0] file_addr_out,
   input wire file_rd_out,
   input wire file_we_out,
   input wire [7:0] file_wdata_out,
   input wire skip_out,
   input wire indexed_out,
   input wire busy_out
);
// ====
// properties
default clocking @(posedge core_clk_in); endclocking
default disable iff (srst_in);
wire [5:0] op = instr_in[15:10];
wire [7:0] f = instr_in[7:0];
wire [7:0] sum = file_rdata_in + 8'h01;
AST_TAKE: assert property (instr_valid_in && !busy_out && !file_rd_out
   && (op == 6'h0F || op == 6'h12) |=> file_rd_out) else $error("request not taken");
AST_WF: assert property (file_rd_out && instr_in[9]
   |=> file_we_out && file_wdata_out == $past(sum)) else $error("bad file write");
AST_ZS: assert property (file_rd_out && op == 6'h0F
   |=> skip_out == ($past(sum) == 8'h00)) else $error("bad zero skip");
AST_NS: assert property (file_rd_out && op == 6'h12
   |=> skip_out == ($past(sum) != 8'h00)) else $error("bad nonzero skip");
AST_BK: assert property (file_rd_out && instr_in[8]
   |-> file_addr_out == {bank_pointer_in, f}) else $error("bad banked address");
AST_IX: assert property (file_rd_out && !instr_in[8] && ext_set_en_in && f <= 8'h5F
   |-> indexed_out && file_addr_out == {4'h0, index_base_in + f}) else $error("bad indexed");
AST_AB: assert property (file_rd_out && !instr_in[8] && !(ext_set_en_in && f <= 8'h5F)
   |-> !indexed_out && file_addr_out == {(f[7] ? 4'hF : 4'h0), f}) else $error("bad access");
endmodule
bind iskx_exec iskx_props u_iskx_props (.*);

//--- bench/testbench.sv
// random and corner-case bench for the increment-and-skip block
`timescale 1ns/1ns
module testbench;
reg core_clk_in = 0, srst_in = 1, instr_valid_in = 0, ext_set_en_in = 0;
reg [15:0] instr_in = 16'h0000;
reg [3:0] bank_pointer_in = 4'h0;
reg [7:0] index_base_in = 8'h00, file_rdata_in = 8'h00;
wire [11:0] file_addr_out, file_waddr_out;
wire [7:0] file_wdata_out, acc_wdata_out;
wire file_rd_out, file_we_out, acc_we_out, skip_out, indexed_out, busy_out;
integer failures = 0, tests_run = 0, i;
reg [31:0] lf = 32'h0388;
iskx_exec u_iskx_exec (.*);
// ====
// helpers
function [31:0] lfsr(input [31:0] s);
   lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
function skip_exp(input [5:0] op, input [7:0] v);
   skip_exp = (op == 6'h0F) ? (v == 8'hFF) : (v != 8'hFF);
endfunction
function [12:0] addr_exp(input [15:0] w, input e, input [3:0] bp, input [7:0] ib);
   if (w[8])
      addr_exp = {1'b0, bp, w[7:0]};
   else if (e && w[7:0] <= 8'h5F)
      addr_exp = {5'h10, 8'(ib + w[7:0])};
   else
      addr_exp = {1'b0, w[7] ? 4'hF : 4'h0, w[7:0]};
endfunction
task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
begin
   tests_run = tests_run + 1;
   if (g !== e)
   begin
      failures = failures + 1;
      $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
   end
end
endtask
task stop_test;
begin
   $display("checks %0d failures %0d", tests_run, failures);
   if (failures == 0 && tests_run > 0)
      $display("Run complete: PASS");
   else
      $display("Run complete: FAIL");
   $finish;
end
endtask
// request held one cycle; data held so the write sees it
task run(input [15:0] w, input [7:0] v);
begin
   @(negedge core_clk_in);
   instr_in = w;
   file_rdata_in = v;
   instr_valid_in = 1;
   @(negedge core_clk_in);
   instr_valid_in = 0;
   chk("rd", 1, file_rd_out);
   chk("addr", addr_exp(w, ext_set_en_in, bank_pointer_in, index_base_in),
      {indexed_out, file_addr_out});
   chk("busy", 1, busy_out);
   @(negedge core_clk_in);
   chk("we", {w[9], !w[9]}, {file_we_out, acc_we_out});
   chk("busy2", skip_exp(w[15:10], v), busy_out);
   if (w[9])
      chk("waddr", addr_exp(w, ext_set_en_in, bank_pointer_in, index_base_in) & 13'h0FFF,
         file_waddr_out);
   chk("wd", 8'(v + 8'h01), w[9] ? file_wdata_out : acc_wdata_out);
   chk("skip", skip_exp(w[15:10], v), skip_out);
   @(negedge core_clk_in);
end
endtask
initial
begin
   forever #50 core_clk_in = ~core_clk_in;
end
initial
begin
   repeat (4) @(negedge core_clk_in);
   srst_in = 0;
   for (i = 0; i < 40; i = i + 1)
   begin
      lf = lfsr(lf);
      ext_set_en_in = lf[20] | (i < 4);
      bank_pointer_in = lf[19:16];
      index_base_in = lf[31:24];
      run({i[0] ? 6'h12 : 6'h0F, lf[9], i < 4 ? 1'b0 : lf[8],
         i < 2 ? 8'h5F : i < 4 ? 8'h60 : lf[7:0]}, i < 4 ? 8'hFF : lf[15:8]);
      $display("test %0d done", i);
   end
   @(negedge core_clk_in);
   instr_in = 16'h2800;
   instr_valid_in = 1;
   @(negedge core_clk_in);
   instr_valid_in = 0;
   chk("ref", 0, file_rd_out);
   stop_test;
end
endmodule
